// file: core/bst_pkg.sv
// shared constants, tap states and instruction codes of the scan port
// assumes both ends compile against this package before anything else
//
// Overview of operation
// [R1] instruction register is ten bits long
// [R2] user signature is 32 bits, seven chosen
// [R3] bypass puts one bit between tdi, tdo
// [R4] user signature instruction shifts signature out
// [R5] identification instruction shifts 32-bit id out
// [R6] sample captures pins, preloads pattern, no disturbance
// [R7] extest drives pattern out, captures input pins
// [R8] no boundary scan while configuration runs
// [R9] extra instructions load configuration over port
// [R10] id: version, part, maker, final bit
// [R11] id lsb is one and leaves first
// [R12] boundary length per part, 690 to 1446
// [R13] port inputs pulled up weakly to one
// [R14] sixteen-state controller, rise sample, fall drive
package bst_pkg;

  // register lengths
  localparam int IR_LEN = 10;
  localparam int ID_LEN = 32;
  localparam int BSR_MIN = 690;
  localparam int BSR_MAX = 1446;

  // instruction codes, all ones is bypass as usual
  localparam logic [9:0] IR_EXTEST = 10'h000;
  localparam logic [9:0] IR_SAMPLE = 10'h005;
  localparam logic [9:0] IR_IDCODE = 10'h006;
  localparam logic [9:0] IR_USERSIG = 10'h007;
  localparam logic [9:0] IR_CFG_PROG = 10'h002;
  localparam logic [9:0] IR_CFG_START = 10'h003;
  localparam logic [9:0] IR_BYPASS = 10'h3ff;
  localparam logic [9:0] IR_CAPTURE = 10'h001;

  // identification fields, values arbitrary
  localparam logic [3:0] ID_VERSION = 4'h3;
  localparam logic [15:0] ID_PART = 16'h5a5a;
  localparam logic [10:0] ID_MAKER = 11'h2a5;
  localparam logic [31:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
  // fixed upper part of the user signature, value arbitrary
  localparam logic [24:0] USER_FIXED = 25'h00c35a;

  // host op word layout
  localparam int OP_W = 40;
  localparam int OP_IR_BIT = 39;
  localparam int OP_MORE_BIT = 38;
  localparam int OP_LEN_HI = 37;
  localparam int OP_LEN_LO = 32;

  // link clock timing, host side
  localparam int CLK_NS = 4;
  localparam int TCK_MIN_NS = 100;
  localparam int TCK_HALF = (TCK_MIN_NS / 2 + CLK_NS - 1) / CLK_NS;
  localparam int RESET_TMS_CNT = 5;

  typedef enum logic [3:0] {
    ts_tlr, ts_idle, ts_sel_dr, ts_cap_dr, ts_sh_dr, ts_ex1_dr, ts_pa_dr, ts_ex2_dr,
    ts_upd_dr, ts_sel_ir, ts_cap_ir, ts_sh_ir, ts_ex1_ir, ts_pa_ir, ts_ex2_ir, ts_upd_ir
  } bst_tap_type;

  // controller step, shared so host tracks the device exactly
  function automatic bst_tap_type bst_tap_next(input bst_tap_type s, input logic tms);
    unique case (s)
      ts_tlr: bst_tap_next = tms ? ts_tlr : ts_idle;
      ts_idle: bst_tap_next = tms ? ts_sel_dr : ts_idle;
      ts_sel_dr: bst_tap_next = tms ? ts_sel_ir : ts_cap_dr;
      ts_cap_dr: bst_tap_next = tms ? ts_ex1_dr : ts_sh_dr;
      ts_sh_dr: bst_tap_next = tms ? ts_ex1_dr : ts_sh_dr;
      ts_ex1_dr: bst_tap_next = tms ? ts_upd_dr : ts_pa_dr;
      ts_pa_dr: bst_tap_next = tms ? ts_ex2_dr : ts_pa_dr;
      ts_ex2_dr: bst_tap_next = tms ? ts_upd_dr : ts_sh_dr;
      ts_upd_dr: bst_tap_next = tms ? ts_sel_dr : ts_idle;
      ts_sel_ir: bst_tap_next = tms ? ts_tlr : ts_cap_ir;
      ts_cap_ir: bst_tap_next = tms ? ts_ex1_ir : ts_sh_ir;
      ts_sh_ir: bst_tap_next = tms ? ts_ex1_ir : ts_sh_ir;
      ts_ex1_ir: bst_tap_next = tms ? ts_upd_ir : ts_pa_ir;
      ts_pa_ir: bst_tap_next = tms ? ts_ex2_ir : ts_pa_ir;
      ts_ex2_ir: bst_tap_next = tms ? ts_upd_ir : ts_sh_ir;
      ts_upd_ir: bst_tap_next = tms ? ts_sel_dr : ts_idle;
    endcase
  endfunction

endpackage

// file: core/bst_if.sv
// the four-wire scan link between controller and device
// assumes the host drives clock and mode pins, the device drives tdo
`timescale 1ns/1ps
interface bst_if;
  logic tck; // link clock, made by the host
  logic tms_o; // host mode-select drive
  logic tdi_o; // host serial data drive
  logic drv_oe_n; // host drives tms and tdi while low
  logic tdo_o; // device serial output drive
  logic tdo_oe_n; // device drives tdo while low
  logic tms; // resolved line levels
  logic tdi;
  logic tdo;

  // undriven lines float high through weak pull-ups
  assign tms = drv_oe_n ? 1'b1 : tms_o; // see [R13]
  assign tdi = drv_oe_n ? 1'b1 : tdi_o; // see [R13]
  assign tdo = tdo_oe_n ? 1'b1 : tdo_o;

  modport host (output tck, output tms_o, output tdi_o, output drv_oe_n, input tdo);
  modport dev (input tck, input tms, input tdi, output tdo_o, output tdo_oe_n);
endinterface

// file: core/bst_dev.sv
// device end of the scan port: controller, instruction and data registers
// assumes rst is synchronous to the link clock and the host walks the tap
`timescale 1ns/1ps
module bst_dev
  import bst_pkg::*;
#(
  parameter int BSR_LEN = 690, // boundary length of this part
  parameter logic [6:0] USER_BITS = 7'h00 // designer-chosen signature bits
) (
  bst_if.dev link,
  input wire logic rst,
  input wire logic [BSR_LEN-1:0] pin_in,
  input wire logic [BSR_LEN-1:0] core_out,
  output logic [BSR_LEN-1:0] pin_out,
  output logic cfg_active,
  output logic [7:0] cfg_byte,
  output logic cfg_stb
);

  // all rising-edge state of the port
  typedef struct packed {
    bst_tap_type tap; // controller state
    logic [IR_LEN-1:0] ir_sh; // instruction shift stage
    logic [IR_LEN-1:0] ir; // current instruction
    logic byp; // one-bit bypass stage
    logic [ID_LEN-1:0] sig; // id or user signature stage
    logic [BSR_LEN-1:0] bsr; // boundary capture/shift stage
    logic [BSR_LEN-1:0] upd; // boundary update latch
    logic [BSR_LEN-1:0] pin_m; // pin synchroniser, first stage
    logic [BSR_LEN-1:0] pin_s; // pin synchroniser, second stage
    logic [BSR_LEN-1:0] core_m; // core synchroniser, first stage
    logic [BSR_LEN-1:0] core_s; // core synchroniser, second stage
    logic [BSR_LEN-1:0] pout; // registered pin drive
    logic ext; // boundary pattern owns the pins
    logic cfg_act; // configuration in progress
    logic [7:0] cfg_sh; // configuration bit collector
    logic [2:0] cfg_cnt; // bits collected so far
    logic [7:0] cfg_byte; // last full configuration byte
    logic cfg_stb; // one-cycle byte strobe
  } bst_dev_state_type;

  // falling-edge state, only the serial output
  typedef struct packed {
    logic tdo; // serial output level
    logic oe_n; // low while driving tdo
  } bst_dev_out_type;

  bst_dev_state_type s_r; // registered state
  bst_dev_state_type s_nxt; // next state
  bst_dev_out_type o_r; // registered serial output
  bst_dev_out_type o_nxt; // its next value

  // next-state logic for both edges
  always_comb begin
    logic bsr_sel;
    logic dr_bit;
    bsr_sel = 1'b0;
    dr_bit = 1'b0;
    s_nxt = s_r;
    s_nxt.cfg_stb = 1'b0;
    // synchronisers; only the second stage is read below
    s_nxt.pin_m = pin_in;
    s_nxt.pin_s = s_r.pin_m;
    s_nxt.core_m = core_out;
    s_nxt.core_s = s_r.core_m;
    // boundary access is refused while configuration runs
    bsr_sel = (s_r.ir == IR_SAMPLE || s_r.ir == IR_EXTEST) && !s_r.cfg_act; // see [R8]
    // tap steered by mode-select on the rising edge
    s_nxt.tap = bst_tap_next(s_r.tap, link.tms); // see [R14]
    case (s_r.tap)
      ts_tlr: begin
        // reset state selects the identification path
        s_nxt.ir = IR_IDCODE;
      end
      ts_cap_ir: begin
        s_nxt.ir_sh = IR_CAPTURE;
      end
      ts_sh_ir: begin
        // full ten-bit instruction shifts lsb first
        s_nxt.ir_sh = {link.tdi, s_r.ir_sh[IR_LEN-1:1]}; // see [R1]
      end
      ts_upd_ir: begin
        s_nxt.ir = s_r.ir_sh;
        s_nxt.cfg_cnt = 3'h0;
        // configuration opens and closes on dedicated instructions
        if (s_r.ir_sh == IR_CFG_PROG) begin
          s_nxt.cfg_act = 1'b1; // see [R9]
        end else if (s_r.ir_sh == IR_CFG_START) begin
          s_nxt.cfg_act = 1'b0; // see [R9]
        end
      end
      ts_cap_dr: begin
        s_nxt.byp = 1'b0;
        // signature: 25 fixed bits above the 7 chosen ones
        if (s_r.ir == IR_USERSIG) begin
          s_nxt.sig = {USER_FIXED, USER_BITS}; // see [R2]
        end else begin
          s_nxt.sig = ID_VALUE; // see [R10]
        end
        // snapshot of the pins, normal drive untouched
        if (bsr_sel) begin
          s_nxt.bsr = s_r.pin_s; // see [R6] [R7]
        end
      end
      ts_sh_dr: begin
        s_nxt.byp = link.tdi; // see [R3]
        // lsb leaves first, so the constant one comes out first
        s_nxt.sig = {link.tdi, s_r.sig[ID_LEN-1:1]}; // see [R11]
        if (bsr_sel) begin
          s_nxt.bsr = {link.tdi, s_r.bsr[BSR_LEN-1:1]}; // see [R12]
        end
        // configuration data gathered into bytes, lsb first
        if (s_r.ir == IR_CFG_PROG) begin
          s_nxt.cfg_sh = {link.tdi, s_r.cfg_sh[7:1]}; // see [R9]
          s_nxt.cfg_cnt = s_r.cfg_cnt + 3'h1;
          if (s_r.cfg_cnt == 3'h7) begin
            s_nxt.cfg_byte = {link.tdi, s_r.cfg_sh[7:1]};
            s_nxt.cfg_stb = 1'b1;
          end
        end
      end
      ts_upd_dr: begin
        // preloaded pattern waits here until extest applies it
        if (bsr_sel) begin
          s_nxt.upd = s_r.bsr; // see [R6]
        end
      end
      default: begin
      end
    endcase
    // pins follow the core unless extest is current and no configuration runs
    s_nxt.ext = (s_r.ir == IR_EXTEST) && !s_r.cfg_act; // see [R7]
    s_nxt.pout = s_r.ext ? s_r.upd : s_r.core_s; // see [R6] [R7]
    // serial path select for the falling edge
    if (s_r.ir == IR_IDCODE || s_r.ir == IR_USERSIG) begin
      dr_bit = s_r.sig[0]; // see [R4] [R5]
    end else if (bsr_sel) begin
      dr_bit = s_r.bsr[0];
    end else begin
      // bypass code, unknown codes and configuration loads
      dr_bit = s_r.byp; // see [R3]
    end
    o_nxt.oe_n = 1'b1;
    o_nxt.tdo = 1'b1;
    if (s_r.tap == ts_sh_ir) begin
      o_nxt.tdo = s_r.ir_sh[0];
      o_nxt.oe_n = 1'b0;
    end else if (s_r.tap == ts_sh_dr) begin
      o_nxt.tdo = dr_bit;
      o_nxt.oe_n = 1'b0;
    end
    if (rst) begin
      s_nxt = '0;
      s_nxt.ir = IR_IDCODE;
      o_nxt.tdo = 1'b1;
      o_nxt.oe_n = 1'b1;
    end
  end

  // rising edge: inputs sampled here
  always_ff @(posedge link.tck) begin
    s_r <= s_nxt;
  end

  // falling edge: tdo changes half a period before the host samples it
  always_ff @(negedge link.tck) begin
    o_r <= o_nxt; // see [R14]
  end

  // outputs straight from flops
  assign link.tdo_o = o_r.tdo;
  assign link.tdo_oe_n = o_r.oe_n;
  assign pin_out = s_r.pout;
  assign cfg_active = s_r.cfg_act;
  assign cfg_byte = s_r.cfg_byte;
  assign cfg_stb = s_r.cfg_stb;

endmodule

// file: core/bst_host.sv
// controller end: queues scan ops, derives the link clock, walks the tap
// assumes one device on the link and a user who drains results
`timescale 1ns/1ps
module bst_fifo #(
  parameter int W = 8, // word width
  parameter int D = 8 // depth, a power of two
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem; // storage
    logic [AW-1:0] wp; // write pointer
    logic [AW-1:0] rp; // read pointer
    logic [AW:0] cnt; // words held
    logic full; // registered so in_ready is a flop
  } bst_fifo_state_type;

  bst_fifo_state_type s_r;
  bst_fifo_state_type s_nxt;

  // push, pop and occupancy
  always_comb begin
    logic push;
    logic pop;
    push = in_valid && !s_r.full;
    pop = out_ready && (s_r.cnt != '0);
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = s_r.wp + AW'(1);
    end
    if (pop) begin
      s_nxt.rp = s_r.rp + AW'(1);
    end
    s_nxt.cnt = s_r.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    s_nxt.full = (s_nxt.cnt == (AW + 1)'(D));
    if (rst) begin
      s_nxt = '0;
    end
  end

  always_ff @(posedge clk) begin
    s_r <= s_nxt;
  end

  assign in_ready = !s_r.full;
  assign out_valid = (s_r.cnt != '0);
  assign out_data = s_r.mem[s_r.rp];
endmodule

module bst_host
  import bst_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  bst_if.host link,
  input wire logic op_valid,
  output logic op_ready,
  input wire logic op_ir,
  input wire logic op_more,
  input wire logic [5:0] op_len,
  input wire logic [31:0] op_data,
  output logic res_valid,
  output logic res_err,
  output logic [31:0] res_data,
  input wire logic res_ready
);

  typedef struct packed {
    logic [4:0] div; // half-period counter
    logic tck; // link clock
    logic tms; // mode-select drive
    logic tdi; // serial data drive
    logic oe_n; // pin drive enable, low while driving
    logic tdo_m; // tdo synchroniser, first stage
    logic tdo_s; // tdo synchroniser, second stage
    bst_tap_type tap; // tracked device state
    logic [2:0] rcnt; // reset mode-select ones sent
    logic job_v; // op being scanned
    logic [OP_W-1:0] job; // that op
    logic [5:0] cnt; // bits shifted of this op
    logic [31:0] cap; // captured tdo bits
    logic more; // park in pause after this op
    logic [IR_LEN-1:0] cur_ir; // last instruction loaded
    logic cfg_busy; // configuration in progress
    logic res_v; // result waiting
    logic res_err; // op refused
    logic [31:0] res_data; // captured bits, right aligned
  } bst_host_state_type;

  bst_host_state_type s_r;
  bst_host_state_type s_nxt;
  logic f_valid; // fifo holds an op
  logic [OP_W-1:0] f_data; // oldest op
  logic pop; // take it

  // results stall the queue, so op_ready drops once it fills
  assign pop = f_valid && !s_r.job_v && !s_r.res_v;

  bst_fifo #(.W(OP_W), .D(8)) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(op_valid),
    .in_data({op_ir, op_more, op_len, op_data}),
    .in_ready(op_ready),
    .out_valid(f_valid),
    .out_data(f_data),
    .out_ready(pop)
  );

  // clock divider, tap walk and op sequencing
  always_comb begin
    logic jir;
    logic [5:0] last;
    logic [31:0] capn;
    jir = s_r.job[OP_IR_BIT];
    last = 6'h1f;
    capn = s_r.cap;
    s_nxt = s_r;
    s_nxt.tdo_m = link.tdo;
    s_nxt.tdo_s = s_r.tdo_m;
    // instruction scans are always the full length
    if (jir) begin
      last = 6'(IR_LEN - 1); // see [R1]
    end else if (s_r.job[OP_LEN_HI:OP_LEN_LO] != 6'h0 && s_r.job[OP_LEN_HI:OP_LEN_LO] <= 6'h20) begin
      last = s_r.job[OP_LEN_HI:OP_LEN_LO] - 6'h1;
    end
    if (s_r.res_v && res_ready) begin
      s_nxt.res_v = 1'b0;
    end
    if (pop) begin
      // boundary scans are refused while configuration runs
      if (!f_data[OP_IR_BIT] && s_r.cfg_busy && (s_r.cur_ir == IR_SAMPLE || s_r.cur_ir == IR_EXTEST)) begin
        s_nxt.res_v = 1'b1; // see [R8]
        s_nxt.res_err = 1'b1;
        s_nxt.res_data = 32'h0;
      end else begin
        s_nxt.job_v = 1'b1;
        s_nxt.job = f_data;
      end
    end
    s_nxt.div = (s_r.div == 5'(TCK_HALF - 1)) ? 5'h0 : s_r.div + 5'h1;
    if (s_r.div == 5'(TCK_HALF - 1)) begin
      s_nxt.tck = !s_r.tck;
      if (!s_r.tck) begin
        // rising edge: device samples, host follows and reads tdo
        s_nxt.tap = bst_tap_next(s_r.tap, s_r.tms); // see [R14]
        if (s_r.rcnt != 3'(RESET_TMS_CNT)) begin
          s_nxt.rcnt = s_r.rcnt + 3'h1;
        end
        if (s_r.tap == ts_cap_dr || s_r.tap == ts_cap_ir || s_r.tap == ts_ex2_dr || s_r.tap == ts_ex2_ir) begin
          s_nxt.cnt = 6'h0;
          s_nxt.cap = 32'h0;
        end
        if (s_r.job_v && (s_r.tap == ts_sh_dr || s_r.tap == ts_sh_ir)) begin
          capn = {s_r.tdo_s, s_r.cap[31:1]};
          s_nxt.cap = capn;
          s_nxt.cnt = s_r.cnt + 6'h1;
          if (s_r.cnt == last) begin
            s_nxt.job_v = 1'b0;
            s_nxt.res_v = 1'b1;
            s_nxt.res_err = 1'b0;
            s_nxt.res_data = capn >> (6'h1f - last);
            // long chains continue across ops through pause
            s_nxt.more = s_r.job[OP_MORE_BIT] && !jir; // see [R12]
            if (jir) begin
              s_nxt.cur_ir = s_r.job[IR_LEN-1:0];
              if (s_r.job[IR_LEN-1:0] == IR_CFG_PROG) begin
                s_nxt.cfg_busy = 1'b1; // see [R9]
              end else if (s_r.job[IR_LEN-1:0] == IR_CFG_START) begin
                s_nxt.cfg_busy = 1'b0; // see [R9]
              end
            end
          end
        end
      end else begin
        // falling edge: set up mode-select and data for the next rise
        s_nxt.oe_n = 1'b0;
        s_nxt.tdi = 1'b1;
        case (s_r.tap)
          ts_tlr: s_nxt.tms = (s_r.rcnt != 3'(RESET_TMS_CNT)); // see [R14]
          ts_idle: s_nxt.tms = s_r.job_v;
          ts_sel_dr: s_nxt.tms = jir;
          ts_sh_dr, ts_sh_ir: begin
            s_nxt.tms = (s_r.cnt == last);
            s_nxt.tdi = s_r.job[s_r.cnt[4:0]];
          end
          ts_ex1_dr: s_nxt.tms = !s_r.more;
          ts_pa_dr, ts_pa_ir: s_nxt.tms = s_r.job_v;
          ts_ex1_ir: s_nxt.tms = 1'b1;
          default: s_nxt.tms = 1'b0;
        endcase
      end
    end
    if (rst) begin
      s_nxt = '0;
      s_nxt.tms = 1'b1;
      s_nxt.tdi = 1'b1;
      s_nxt.oe_n = 1'b1;
      s_nxt.cur_ir = IR_IDCODE;
    end
  end

  always_ff @(posedge clk) begin
    s_r <= s_nxt;
  end

  // outputs straight from flops
  assign link.tck = s_r.tck;
  assign link.tms_o = s_r.tms;
  assign link.tdi_o = s_r.tdi;
  assign link.drv_oe_n = s_r.oe_n;
  assign res_valid = s_r.res_v;
  assign res_err = s_r.res_err;
  assign res_data = s_r.res_data;

endmodule

// file: verification/bst_link_checker.sv
// link checker: timing and framing of the scan wires
// assumes clk makes tck and dev_rst is synchronous to tck
`timescale 1ns/1ps
module bst_link_checker
  import bst_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic dev_rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tms_o,
  input wire logic tdi_o,
  input wire logic drv_oe_n,
  input wire logic tdo_o,
  input wire logic tdo_oe_n
);
  localparam int HALF_MIN = TCK_HALF - 1; // edges counted before a legal toggle
  logic tck_d_r; // tck one clk ago
  logic [4:0] half_cnt_r; // clk edges since tck moved, saturating

  // held full in reset so the first phase after release passes
  always_ff @(posedge clk) begin
    tck_d_r <= tck;
    if (rst) begin
      half_cnt_r <= 5'h1f;
    end else if (tck != tck_d_r) begin
      half_cnt_r <= 5'h00;
    end else if (half_cnt_r != 5'h1f) begin
      half_cnt_r <= half_cnt_r + 5'h01;
    end
  end

  // five rises with mode high always park the controller
  sequence s_five_ones;
    tms [*5];
  endsequence

  property p_tck_half;
    @(posedge clk) disable iff (rst) $changed(tck) |-> half_cnt_r >= HALF_MIN;
  endproperty
  a_tck_half: assert property (p_tck_half) else $error("tck phase too short");

  property p_host_edge;
    @(posedge clk) disable iff (rst) ($changed(tms_o) || $changed(tdi_o)) |-> $fell(tck);
  endproperty
  a_host_edge: assert property (p_host_edge) else $error("host drive moved off the falling edge");

  property p_dev_edge;
    @(posedge clk) disable iff (rst || dev_rst) ($changed(tdo_o) || $changed(tdo_oe_n)) |-> $fell(tck);
  endproperty
  a_dev_edge: assert property (p_dev_edge) else $error("tdo moved off the falling edge");

  property p_rst_idle;
    @(posedge clk) disable iff (dev_rst && !rst) rst && $past(rst) |-> drv_oe_n && !tck;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("host drives the link in reset");

  property p_dev_quiet;
    @(posedge tck) disable iff (rst) dev_rst && $past(dev_rst) |-> tdo_oe_n;
  endproperty
  a_dev_quiet: assert property (p_dev_quiet) else $error("tdo driven in device reset");

  property p_tlr_quiet;
    @(posedge tck) disable iff (rst || dev_rst) s_five_ones ##1 1'h1 |-> tdo_oe_n;
  endproperty
  a_tlr_quiet: assert property (p_tlr_quiet) else $error("tdo driven after reset walk");

  property p_oe_enter;
    @(posedge tck) disable iff (dev_rst) $fell(tdo_oe_n) |-> !$past(tms);
  endproperty
  a_oe_enter: assert property (p_oe_enter) else $error("tdo enabled without a shift entry");

  property p_oe_leave;
    @(posedge tck) disable iff (dev_rst) $rose(tdo_oe_n) |-> $past(tms);
  endproperty
  a_oe_leave: assert property (p_oe_leave) else $error("tdo released without a shift exit");
endmodule

// file: verification/tb_top.sv
// testbench: host and device ends joined by the link, results checked against a queue model
// assumes one device on the link, host clock 250 MHz
`timescale 1ns/1ps
module tb_top
  import bst_pkg::*;
;
  localparam int BL = 690; // boundary length of the part under test
  localparam logic [6:0] UB = 7'h5b; // chosen signature bits
  logic clk, rst, dev_rst, op_valid, op_ready, op_ir, op_more, res_valid, res_err, res_ready;
  logic [5:0] op_len;
  logic [31:0] op_data, res_data;
  logic [BL-1:0] pin_in, core_out, pin_out; // pin side of the boundary
  logic cfg_active, cfg_stb;
  logic [7:0] cfg_byte;
  logic [31:0] exp_q[$], msk_q[$]; // model: expected results and compare masks
  logic err_q[$]; // model: expected refusal flags
  logic [7:0] cfg_q[$]; // config bytes seen on the strobe
  logic [31:0] rnd, rr; // lfsr states, stimulus and stall
  logic [703:0] pat, pins; // boundary pattern in, pin levels out
  logic hold_res; // blocks the result side
  int bad_count, n_checks, cyc;

  bst_if link();
  bst_host u_bst_host(.clk, .rst, .link(link), .op_valid, .op_ready, .op_ir, .op_more, .op_len, .op_data,
    .res_valid, .res_err, .res_data, .res_ready);
  bst_dev #(.BSR_LEN(BL), .USER_BITS(UB)) u_bst_dev(.link(link), .rst(dev_rst), .pin_in, .core_out,
    .pin_out, .cfg_active, .cfg_byte, .cfg_stb);
  bst_link_checker u_bst_link_checker(.clk, .rst, .dev_rst, .tck(link.tck), .tms(link.tms),
    .tms_o(link.tms_o), .tdi_o(link.tdi_o), .drv_oe_n(link.drv_oe_n), .tdo_o(link.tdo_o),
    .tdo_oe_n(link.tdo_oe_n));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // mask of the captured bits of a scan of len bits
  function automatic logic [31:0] lmask(input int len);
    return (len >= 32) ? 32'hffffffff : ((32'h1 << len) - 32'h1);
  endfunction
  task automatic fail(input string msg);
    bad_count++;
    $display("MISMATCH t=%0t %s", $time, msg);
  endtask
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'h1) fail(msg);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // offer one op and record its expected result; op_valid is left high for back-to-back use
  task automatic send_op(input logic ir, input logic more, input int len, input logic [31:0] d,
    input logic [31:0] e, input logic er, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    err_q.push_back(er);
    op_ir <= ir;
    op_more <= more;
    op_len <= 6'(len);
    op_data <= d;
    op_valid <= 1'h1;
    @(posedge clk);
    while (op_ready !== 1'h1) @(posedge clk);
  endtask
  task automatic ir_load(input logic [9:0] code);
    send_op(1'h1, 1'h0, 10, {22'h0, code}, 32'h001, 1'h0, 32'h3ff);
  endtask
  // wait for every result, then let update and pin latency pass
  task automatic drain();
    op_valid <= 1'h0;
    while (exp_q.size() != 0) @(posedge clk);
    repeat (6) @(posedge link.tck);
    @(posedge clk);
  endtask
  task automatic new_pats();
    for (int i = 0; i < 22; i++) begin
      rnd = lfsr(rnd);
      pat[i*32 +: 32] = rnd;
      rnd = lfsr(rnd);
      pins[i*32 +: 32] = rnd;
    end
    pin_in <= pins[BL-1:0];
  endtask
  // whole boundary in 32-bit pieces chained by op_more, last piece 18 bits
  task automatic bsr_scan();
    for (int k = 0; k < 22; k++)
      send_op(1'h0, k < 21, (k < 21) ? 32 : 18, pat[k*32 +: 32], pins[k*32 +: 32], 1'h0,
        lmask((k < 21) ? 32 : 18));
    drain();
  endtask

  always #2 clk = ~clk;

  // result side: random stall, each result compared with the head of the model
  always @(posedge clk) begin
    rr <= lfsr(rr);
    res_ready <= !hold_res && rr[3];
    if (res_valid === 1'h1 && res_ready === 1'h1) begin
      if (exp_q.size() == 0) fail("result without a request");
      else begin
        n_checks++;
        if ((res_data & msk_q[0]) !== (exp_q[0] & msk_q[0]) || res_err !== err_q[0])
          fail($sformatf("result %h err %b want %h", res_data, res_err, exp_q[0]));
        void'(exp_q.pop_front());
        void'(msk_q.pop_front());
        void'(err_q.pop_front());
      end
    end
  end
  always @(posedge link.tck) if (cfg_stb === 1'h1) cfg_q.push_back(cfg_byte);
  // hang guard, about half again the expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 95000) begin
      fail("timeout");
      complete_run();
    end
  end
  // device reset needs tck running, released off its sampling edge
  initial begin
    dev_rst = 1'h1;
    wait (rst === 1'h0);
    repeat (3) @(posedge link.tck);
    @(negedge link.tck);
    dev_rst <= 1'h0;
  end

  initial begin
    logic [9:0] codes[2];
    int lens[3];
    codes = '{IR_BYPASS, 10'h155};
    lens = '{1, 13, 32};
    clk = 1'h0;
    rst = 1'h1;
    hold_res = 1'h1;
    res_ready = 1'h0;
    op_valid = 1'h0;
    op_ir = 1'h0;
    op_more = 1'h0;
    op_len = 6'h00;
    op_data = 32'h0;
    rnd = 32'h20;
    rr = 32'h20;
    new_pats();
    core_out = pat[703:14];
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    // nine reads during the reset walk: one in flight, eight fill the queue; results held back
    for (int i = 0; i < 9; i++) send_op(1'h0, 1'h0, 32, rnd + i, ID_VALUE, 1'h0, 32'hffffffff);
    op_valid <= 1'h0;
    @(posedge clk);
    chk(op_ready === 1'h0, "queue accepts a ninth op");
    hold_res <= 1'h0;
    drain();
    chk(pin_out === core_out, "pins do not follow the core");
    ir_load(IR_USERSIG);
    send_op(1'h0, 1'h0, 32, rnd, {USER_FIXED, UB}, 1'h0, 32'hffffffff);
    // bypass and an unknown code: one stage, captured zero first
    foreach (codes[c]) begin
      ir_load(codes[c]);
      foreach (lens[j]) begin
        rnd = lfsr(rnd);
        send_op(1'h0, 1'h0, lens[j], rnd, {rnd[30:0], 1'h0}, 1'h0, lmask(lens[j]));
      end
    end
    drain();
    new_pats();
    ir_load(IR_SAMPLE);
    bsr_scan();
    chk(pin_out === core_out, "sample disturbed the pins");
    ir_load(IR_EXTEST);
    drain();
    chk(pin_out === pat[BL-1:0], "preload not driven");
    new_pats();
    bsr_scan();
    chk(pin_out === pat[BL-1:0], "extest pattern not driven");
    ir_load(IR_CFG_PROG);
    drain();
    chk(cfg_active === 1'h1, "configuration not started");
    rnd = lfsr(rnd);
    // config loads leave tdo on the bypass stage
    send_op(1'h0, 1'h0, 16, rnd, {rnd[30:0], 1'h0}, 1'h0, lmask(16));
    drain();
    chk(cfg_q.size() == 2 && cfg_q[0] === rnd[7:0] && cfg_q[1] === rnd[15:8], "config bytes");
    ir_load(IR_SAMPLE);
    send_op(1'h0, 1'h0, 32, rnd, 32'h0, 1'h1, 32'hffffffff);
    ir_load(IR_CFG_START);
    drain();
    chk(cfg_active === 1'h0, "configuration not ended");
    // mid-run host reset: its five-ones walk alone must park the device back on the id path
    rst <= 1'h1;
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    rnd = lfsr(rnd);
    send_op(1'h0, 1'h0, 32, rnd, ID_VALUE, 1'h0, 32'hffffffff);
    drain();
    complete_run();
  end
endmodule
